// ===== apm_pkg.sv
// Package: constants, modes and carriers for the address path and page map
package apm_pkg;
   // Address and data geometry
   localparam int DATA_W     = 16;
   localparam int LADDR_W    = 16;
   localparam int PADDR_W    = 19;
   localparam int FRAME_W    = 8;
   localparam int PAGE_W     = 5;
   localparam int TBL_W      = 4;
   localparam int PG_OFF_W   = 11;
   localparam int MAP_DEPTH  = 512;
   localparam int CIDX_W     = 10;
   localparam int C_DEPTH    = 1024;
   localparam int CENT_W     = FRAME_W + DATA_W;
   localparam int AXI_AW     = 8;
   // Addressing reach, in bytes except REL_WFWD, which is in words
   localparam logic [15:0] SCR_LIMIT    = 16'h0200;
   localparam logic [15:0] REL_WFWD     = 16'h0100;
   localparam logic [9:0]  REL_BFWD     = 10'h200;
   localparam logic [15:0] REL_WFWD_B   = 16'h0200;
   localparam logic [15:0] REL_WBACK_B  = 16'h01fe;
   // Addressing modes carried in the instruction
   localparam logic [2:0] MODE_SCR   = 3'h0;
   localparam logic [2:0] MODE_REL   = 3'h1;
   localparam logic [2:0] MODE_IDX   = 3'h2;
   localparam logic [2:0] MODE_ISCR  = 3'h3;
   localparam logic [2:0] MODE_IREL  = 3'h4;
   localparam logic [2:0] MODE_PUSH  = 3'h5;
   localparam logic [2:0] MODE_POP   = 3'h6;
   localparam logic [2:0] MODE_SIDX  = 3'h7;
   // Register offsets (byte addresses)
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STAT   = 8'h04;
   localparam logic [7:0] REG_INDEX  = 8'h08;
   localparam logic [7:0] REG_STACK  = 8'h0c;
   localparam logic [7:0] REG_MAPIX  = 8'h10;
   localparam logic [7:0] REG_MAPDT  = 8'h14;
   localparam logic [7:0] REG_HITS   = 8'h18;
   // Control fields
   localparam int CTRL_WBS   = 0;
   localparam int CTRL_PERM  = 1;
   localparam int CTRL_CTBL  = 4;
   localparam int CTRL_DTBL  = 8;
   localparam int CTRL_FLUSH = 16;
   localparam int STAT_ARF   = 0;
   localparam int STAT_BUSY  = 1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_MAP  = 2'h1,
      ST_CHK  = 2'h3,
      ST_MEM  = 2'h2
   } apm_state_e;

   typedef struct packed {
      logic [2:0]        mode;
      logic [15:0]       field;
      logic [15:0]       pc;
      logic              we;
      logic [DATA_W-1:0] wdata;
      logic              dma;
   } apm_req_s;

   typedef struct packed {
      logic               valid;
      logic               we;
      logic               byte_acc;
      logic [PADDR_W-1:0] addr;
      logic [DATA_W-1:0]  wdata;
   } apm_mem_s;
endpackage

// ===== apm_ram.sv
// Simple dual-port memory with registered read data
`timescale 1ns/1ps
module apm_ram #(
   parameter int W = 8,
   parameter int D = 512,
   parameter int A = $clog2(D)
) (
   // Clock and enable
   input  wire logic         clk_i,
   input  wire logic         en_i,
   // Write port
   input  wire logic         we_i,
   input  wire logic [A-1:0] waddr_i,
   input  wire logic [W-1:0] wdata_i,
   // Read port
   input  wire logic         re_i,
   input  wire logic [A-1:0] raddr_i,
   output logic      [W-1:0] rdata_o
);
   logic [W-1:0] mem_r [D];

   always_ff @(posedge clk_i) begin
      if (en_i && we_i) begin
         mem_r[waddr_i] <= wdata_i;
      end
   end

   // No reset: contents are qualified elsewhere
   always_ff @(posedge clk_i) begin
      if (en_i && re_i) begin
         rdata_o <= mem_r[raddr_i];
      end
   end
endmodule // apm_ram

// ===== apm_top.sv
// Address generation, page map translation and word cache
//
// Contract
// - Scratchpad reaches first 256 words, or first 512 bytes in byte mode.
// - Word relative reaches 256 words forward, 255 words backward.
// - Byte relative reaches forward up to 512 bytes only.
// - Indexed address is address field plus index register.
// - Indirect fetches a pointer word, then uses it as operand address.
// - Push predecrements stack pointer; pop postincrements it.
// - Stack-indexed access leaves stack pointer unchanged.
// - Three instruction bits select the addressing mode.
// - One select bit chooses word or byte references.
// - Arithmetic range flag is set on every overflow.
// - Interrupt permit bit gates interruption; clear holds interrupts off.
// - Logical space is 64K bytes; more only through translation.
// - Every processor and DMA address is translated before memory access.
// - Pages are 2K bytes, 32 pages in logical space.
// - Sixteen page tables, any one supplies translation.
// - Cache returns retained copy on repeated access.
// - Cache holds 1024 words; byte accesses bypass it.
`timescale 1ns/1ps
module apm_top
   import apm_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                clk_i,
   input  wire logic                srst_i,
   input  wire logic                ce_i,
   // AXI4-Lite slave
   input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   // Core and DMA requests
   input  wire logic                req_valid_i,
   input  wire apm_req_s            req_i,
   output logic                     req_ready_o,
   output logic                     core_ack_o,
   output logic [DATA_W-1:0]        core_rdata_o,
   // Core status events
   input  wire logic                ovf_i,
   input  wire logic                irq_req_i,
   output logic                     irq_take_o,
   // Memory modules
   output apm_mem_s                 mem_o,
   input  wire logic                mem_ack_i,
   input  wire logic [DATA_W-1:0]   mem_rdata_i
);
   apm_state_e          st_r;
   apm_req_s            req_r;
   logic [15:0]         lg_addr_r;
   logic                ptr_r;
   logic                byte_r;
   logic                word_byte_select;
   logic                interrupt_permit_bit;
   logic                arith_range_flag;
   logic [TBL_W-1:0]    ctbl_r;
   logic [TBL_W-1:0]    dtbl_r;
   logic [15:0]         x_r;
   logic [15:0]         sp_r;
   logic [8:0]          mapix_r;
   logic [7:0]          mapdt_r;
   logic [15:0]         hits_r;
   logic [C_DEPTH-1:0]  cvalid_r;
   logic [AXI_AW-1:0]   awaddr_r;
   logic [31:0]         wdata_r;
   logic [3:0]          wstrb_r;
   logic [FRAME_W-1:0]  map_q;
   logic [CENT_W-1:0]   cache_q;

   function automatic logic [15:0] w2b(input logic [15:0] w);
      return {w[14:0], 1'b0};
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] m;
      m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      return (o & ~m) | (n & m);
   endfunction

   function automatic logic [15:0] calc_ea(input apm_req_s r, input logic bm,
                                           input logic [15:0] x, input logic [15:0] sp);
      logic [15:0] d;
      logic [9:0]  bo;
      d  = (r.field[8:0] <= 9'h100) ? {7'h00, r.field[8:0]} : {7'h7f, r.field[8:0]};
      bo = (r.field[9:0] > REL_BFWD) ? REL_BFWD : r.field[9:0];
      case (r.mode)
         MODE_SCR:  calc_ea = bm ? {7'h00, r.field[8:0]} : {7'h00, r.field[7:0], 1'b0};
         MODE_REL:  calc_ea = bm ? w2b(r.pc) + {6'h00, bo} : w2b(r.pc + d);
         MODE_IDX:  calc_ea = bm ? r.field + x : w2b(r.field + x);
         MODE_ISCR: calc_ea = {7'h00, r.field[7:0], 1'b0};
         MODE_IREL: calc_ea = w2b(r.pc + d);
         MODE_PUSH: calc_ea = w2b(sp - 16'h0001);
         MODE_POP:  calc_ea = w2b(sp);
         MODE_SIDX: calc_ea = w2b(sp + r.field);
         default:   calc_ea = 16'h0000;
      endcase
   endfunction

   // AXI write side
   logic       wr_go;
   logic [7:0] wr_a;
   logic [31:0] wd;
   assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wr_a  = awaddr_r;
   assign wd    = wmask(32'h0000_0000, wdata_r, wstrb_r);

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         awaddr_r      <= '0;
         wdata_r       <= '0;
         wstrb_r       <= '0;
      end else if (ce_i) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r      <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_a > REG_HITS || wr_a[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Software-owned control; flush is a one-shot
   logic flush;
   assign flush = wr_go && wr_a == REG_CTRL && wd[CTRL_FLUSH];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         word_byte_select     <= 1'b0;
         interrupt_permit_bit <= 1'b0;
         ctbl_r               <= '0;
         dtbl_r               <= '0;
         x_r                  <= '0;
         mapix_r              <= '0;
         mapdt_r              <= '0;
      end else if (ce_i && wr_go) begin
         case (wr_a)
            REG_CTRL: begin
               // select bits
               // Both bits live in byte lane 0
               word_byte_select     <= 1'(wmask({31'h0, word_byte_select},
                                                wdata_r >> CTRL_WBS, wstrb_r));
               interrupt_permit_bit <= 1'(wmask({31'h0, interrupt_permit_bit},
                                                wdata_r >> CTRL_PERM, wstrb_r));
               ctbl_r <= wstrb_r[0] ? wdata_r[CTRL_CTBL +: TBL_W] : ctbl_r;
               dtbl_r <= wstrb_r[1] ? wdata_r[CTRL_DTBL +: TBL_W] : dtbl_r;
            end
            REG_INDEX: x_r     <= 16'(wmask({16'h0, x_r}, wdata_r, wstrb_r));
            REG_MAPIX: mapix_r <= 9'(wmask({23'h0, mapix_r}, wdata_r, wstrb_r));
            REG_MAPDT: mapdt_r <= wd[7:0];
            default: ;
         endcase
      end
   end

   // Request acceptance and finish
   logic              acc;
   logic              is_wr;
   logic              rd_hit;
   logic              fin;
   logic [DATA_W-1:0] fin_data;
   logic [CIDX_W-1:0] cidx;
   assign acc    = req_valid_i && req_ready_o;
   assign is_wr  = req_r.we && !ptr_r;
   assign cidx   = lg_addr_r[10:1];
   assign rd_hit = !is_wr && !byte_r && cvalid_r[cidx] && cache_q[CENT_W-1 -: FRAME_W] == map_q;
   assign fin    = (st_r == ST_CHK && rd_hit) || (st_r == ST_MEM && mem_ack_i);
   always_comb begin
      fin_data = mem_rdata_i;
      if (st_r == ST_CHK) begin
         fin_data = cache_q[DATA_W-1:0];
      end else if (byte_r) begin
         fin_data = {8'h00, mem_o.addr[0] ? mem_rdata_i[15:8] : mem_rdata_i[7:0]};
      end
   end

   // Stack pointer: hardware update has priority over software
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sp_r <= '0;
      end else if (ce_i) begin
         // push before write, pop after read
         if (acc && !req_i.dma && req_i.mode == MODE_PUSH) begin
            sp_r <= sp_r - 16'h0001;
         end else if (fin && !ptr_r && !req_r.dma && req_r.mode == MODE_POP) begin
            sp_r <= sp_r + 16'h0001;
         end else if (wr_go && wr_a == REG_STACK) begin
            sp_r <= 16'(wmask({16'h0, sp_r}, wdata_r, wstrb_r));
         end
      end
   end

   // Main sequencer
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         st_r         <= ST_IDLE;
         req_r        <= '0;
         lg_addr_r    <= '0;
         ptr_r        <= 1'b0;
         byte_r       <= 1'b0;
         req_ready_o  <= 1'b1;
         core_ack_o   <= 1'b0;
         core_rdata_o <= '0;
         mem_o        <= '0;
         hits_r       <= '0;
      end else if (ce_i) begin
         core_ack_o <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (acc) begin
                  req_r       <= req_i;
                  req_ready_o <= 1'b0;
                  st_r        <= ST_MAP;
                  // DMA addresses take the same path
                  lg_addr_r   <= req_i.dma ? req_i.field
                                           : calc_ea(req_i, word_byte_select, x_r, sp_r);
                  ptr_r  <= !req_i.dma && (req_i.mode == MODE_ISCR || req_i.mode == MODE_IREL);
                  byte_r <= !req_i.dma && word_byte_select && req_i.mode <= MODE_IDX;
               end
            end
            ST_MAP: st_r <= ST_CHK;
            ST_CHK: begin
               if (rd_hit) begin
                  hits_r <= hits_r + 16'h0001;
               end else begin
                  mem_o.valid    <= 1'b1;
                  mem_o.we       <= is_wr;
                  mem_o.byte_acc <= byte_r;
                  mem_o.addr     <= {map_q, lg_addr_r[PG_OFF_W-1:0]};
                  mem_o.wdata    <= !byte_r ? req_r.wdata :
                                    lg_addr_r[0] ? {req_r.wdata[7:0], 8'h00}
                                                 : {8'h00, req_r.wdata[7:0]};
                  st_r           <= ST_MEM;
               end
            end
            ST_MEM: begin
               if (mem_ack_i) begin
                  mem_o.valid <= 1'b0;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
         if (fin) begin
            if (ptr_r) begin
               ptr_r     <= 1'b0;
               byte_r    <= word_byte_select;
               lg_addr_r <= word_byte_select ? fin_data : w2b(fin_data);
               st_r      <= ST_MAP;
            end else begin
               core_ack_o   <= 1'b1;
               core_rdata_o <= fin_data;
               req_ready_o  <= 1'b1;
               st_r         <= ST_IDLE;
            end
         end
      end
   end

   logic [TBL_W-1:0] tbl;
   assign tbl = req_r.dma ? dtbl_r : ctbl_r;

   apm_ram #(.W(FRAME_W), .D(MAP_DEPTH)) u_map (
      .clk_i   (clk_i),
      .en_i    (ce_i),
      .we_i    (wr_go && wr_a == REG_MAPDT),
      .waddr_i (mapix_r),
      .wdata_i (wd[7:0]),
      .re_i    (st_r == ST_MAP),
      .raddr_i ({tbl, lg_addr_r[15:PG_OFF_W]}),
      .rdata_o (map_q)
   );

   logic cw_en;
   assign cw_en = st_r == ST_MEM && mem_ack_i && !byte_r;

   apm_ram #(.W(CENT_W), .D(C_DEPTH)) u_cache (
      .clk_i   (clk_i),
      .en_i    (ce_i),
      .we_i    (cw_en),
      .waddr_i (cidx),
      .wdata_i ({map_q, mem_o.we ? mem_o.wdata : mem_rdata_i}),
      .re_i    (st_r == ST_MAP),
      .raddr_i (cidx),
      .rdata_o (cache_q)
   );

   // Valid bits; byte writes drop the line to stay coherent
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         cvalid_r <= '0;
      end else if (ce_i) begin
         if (flush) begin
            cvalid_r <= '0;
         end else if (cw_en) begin
            cvalid_r[cidx] <= 1'b1;
         end else if (st_r == ST_MEM && mem_ack_i && mem_o.we) begin
            cvalid_r[cidx] <= 1'b0;
         end
      end
   end

   // Range flag: overflow wins over the clear
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         arith_range_flag <= 1'b0;
         irq_take_o       <= 1'b0;
      end else if (ce_i) begin
         if (ovf_i) begin
            arith_range_flag <= 1'b1;
         end else if (wr_go && wr_a == REG_STAT && wd[STAT_ARF]) begin
            arith_range_flag <= 1'b0;
         end
         irq_take_o <= irq_req_i && interrupt_permit_bit;
      end
   end

   // AXI read side
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (ce_i) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (s_axi_araddr)
               REG_CTRL:  s_axi_rdata <= {20'h0, dtbl_r, ctbl_r, 2'h0,
                                          interrupt_permit_bit, word_byte_select};
               REG_STAT:  s_axi_rdata <= {30'h0, !req_ready_o, arith_range_flag};
               REG_INDEX: s_axi_rdata <= {16'h0, x_r};
               REG_STACK: s_axi_rdata <= {16'h0, sp_r};
               REG_MAPIX: s_axi_rdata <= {23'h0, mapix_r};
               REG_MAPDT: s_axi_rdata <= {24'h0, mapdt_r};
               REG_HITS:  s_axi_rdata <= {16'h0, hits_r};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Checks
   logic signed [15:0] rel_diff;
   assign rel_diff = $signed(lg_addr_r - w2b(req_r.pc));

   property p_scr;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && acc && !req_i.dma && req_i.mode == MODE_SCR) |=> lg_addr_r < SCR_LIMIT;
   endproperty
   a_scr: assert property (p_scr) else $error("scratchpad out of reach");
   property p_wrel;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && acc && !req_i.dma && req_i.mode == MODE_REL && !word_byte_select)
      |=> rel_diff <= $signed(REL_WFWD_B) && rel_diff >= -$signed(REL_WBACK_B);
   endproperty
   a_wrel: assert property (p_wrel) else $error("word relative out of reach");
   property p_brel;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && acc && !req_i.dma && req_i.mode == MODE_REL && word_byte_select)
      |=> (lg_addr_r - w2b(req_r.pc)) <= SCR_LIMIT;
   endproperty
   a_brel: assert property (p_brel) else $error("byte relative not forward");
   property p_push;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && acc && !req_i.dma && req_i.mode == MODE_PUSH)
      |=> sp_r == $past(sp_r) - 16'h0001 && lg_addr_r == w2b(sp_r);
   endproperty
   a_push: assert property (p_push) else $error("push did not predecrement");
   property p_sidx;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && acc && !req_i.dma && req_i.mode == MODE_SIDX) |=> $stable(sp_r);
   endproperty
   a_sidx: assert property (p_sidx) else $error("stack pointer altered");
   property p_xlat;
      @(posedge clk_i) disable iff (srst_i)
      mem_o.valid |-> mem_o.addr == {map_q, lg_addr_r[PG_OFF_W-1:0]};
   endproperty
   a_xlat: assert property (p_xlat) else $error("untranslated memory address");
   property p_byp;
      @(posedge clk_i) disable iff (srst_i)
      (st_r == ST_CHK && byte_r) |-> !rd_hit ##1 mem_o.valid;
   endproperty
   a_byp: assert property (p_byp) else $error("byte access used cache");
   property p_hit;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && st_r == ST_CHK && rd_hit && !ptr_r)
      |=> core_ack_o && core_rdata_o == $past(cache_q[DATA_W-1:0]) && !mem_o.valid;
   endproperty
   a_hit: assert property (p_hit) else $error("hit not served from cache");
   property p_ovf;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && ovf_i) |=> arith_range_flag;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not flagged");
   property p_perm;
      @(posedge clk_i) disable iff (srst_i)
      (ce_i && !interrupt_permit_bit) |=> !irq_take_o;
   endproperty
   a_perm: assert property (p_perm) else $error("interrupt passed while held off");
   c_hit:  cover property (@(posedge clk_i) disable iff (srst_i) st_r == ST_CHK && rd_hit);
   c_ind:  cover property (@(posedge clk_i) disable iff (srst_i) fin && ptr_r);
   c_fill: cover property (@(posedge clk_i) disable iff (srst_i) cw_en && !mem_o.we);
endmodule // apm_top

// ===== apm_mem_model.sv
// Memory module model answering translated requests
`timescale 1ns/1ps
module apm_mem_model
   import apm_pkg::*;
(
   // Clock and latency
   input  wire logic         clk_i,
   input  wire logic [3:0]   dly_i,
   // Memory side
   input  wire apm_mem_s     mem_i,
   output logic              ack_o,
   output logic [DATA_W-1:0] rdata_o
);
   logic [DATA_W-1:0] st [logic [17:0]];
   int                cnt = 0;
   initial ack_o = 1'b0;
   initial rdata_o = 16'h0000;
   // Idle data toggles so a stale read never looks right
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (mem_i.valid && !ack_o) begin
         if (cnt < int'(dly_i)) begin
            cnt <= cnt + 1;
         end else begin
            cnt <= 0;
            ack_o <= 1'b1;
            if (mem_i.we) st[mem_i.addr[18:1]] = mem_i.wdata;
            if (st.exists(mem_i.addr[18:1])) rdata_o <= st[mem_i.addr[18:1]];
            else rdata_o <= mem_i.addr[16:1] ^ 16'ha5c3;
         end
      end
   end
endmodule // apm_mem_model

// ===== tb.sv
// Self-checking testbench for the address path and page map
`timescale 1ns/1ps
module tb
   import apm_pkg::*;
;
   typedef struct packed {logic [2:0] m; logic [15:0] f, p, l;} apm_row_s;
   logic        clk = 0, srst = 1, awv = 0, wv = 0, arv = 0, rv = 0, ovf = 0, irq = 0;
   logic        awr, wr, bvl, arr, rvl, rdy, ack, itk, mack;
   logic [7:0]  awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, rdat;
   logic [1:0]  br, rr, rrsp, bq;
   logic [15:0] crd, mrd, got, e;
   logic [3:0]  dly = 0;
   apm_req_s    req = '0;
   apm_mem_s    mem;
   int          fails = 0, tests_run = 0, nmem = 0, nbyte = 0, n0, b0;
   apm_row_s    rows [7] = '{'{MODE_SCR, 16'h00ff, 16'h0, 16'h01fe},
      '{MODE_REL, 16'h0100, 16'h0400, 16'h0a00}, '{MODE_REL, 16'h0101, 16'h0400, 16'h0602},
      '{MODE_IDX, 16'h0010, 16'h0, 16'h0060}, '{MODE_ISCR, 16'h0005, 16'h0, 16'h000a},
      '{MODE_IREL, 16'h0002, 16'h0400, 16'h0804}, '{MODE_SIDX, 16'h0003, 16'h0, 16'h0206}};
   apm_top apm_top_inst (.clk_i(clk), .srst_i(srst), .ce_i(1'b1), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bvl),
      .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rrsp), .s_axi_rvalid(rvl), .s_axi_rready(1'b1),
      .req_valid_i(rv), .req_i(req), .req_ready_o(rdy), .core_ack_o(ack), .core_rdata_o(crd),
      .ovf_i(ovf), .irq_req_i(irq), .irq_take_o(itk), .mem_o(mem), .mem_ack_i(mack),
      .mem_rdata_i(mrd));
   apm_mem_model apm_mem_model_inst (.clk_i(clk), .dly_i(dly), .mem_i(mem), .ack_o(mack),
      .rdata_o(mrd));
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin
      if (mack) nmem++;
      if (mack && mem.byte_acc) nbyte++;
   end
   function automatic logic [18:0] ph(input logic [15:0] l);
      return {3'h1, l};
   endfunction
   function automatic logic [15:0] dat(input logic [18:0] a);
      return a[16:1] ^ 16'ha5c3;
   endfunction
   task automatic chk(input logic [31:0] s, x);
      tests_run++;
      if (s !== x) begin
         fails++;
         $display("mismatch at %0t: saw %h want %h", $time, s, x);
      end
   endtask
   task automatic report_and_stop;
      if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      forever begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
         if (bvl) begin
            bq = br;
            break;
         end
      end
   endtask
   task automatic axr(input logic [7:0] a);
      ara <= a;
      arv <= 1'b1;
      forever begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
         if (rvl) break;
      end
      rd = rdat;
      rr = rrsp;
   endtask
   task automatic cop(input logic [2:0] m, input logic [15:0] f, p, w, input logic we, dm);
      req <= '{mode: m, field: f, pc: p, we: we, wdata: w, dma: dm};
      rv <= 1'b1;
      do @(posedge clk); while (!rdy);
      rv <= 1'b0;
      do @(posedge clk); while (!ack);
      got = crd;
   endtask
   initial begin
      repeat (30000) @(posedge clk);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(rdy, 1'b1);
      for (int p = 0; p < 32; p++) begin
         axw(REG_MAPIX, 32'(p));
         axw(REG_MAPDT, 32'(p + 32));
      end
      axw(REG_MAPIX, 32'h20);
      axw(REG_MAPDT, 32'h77);
      axw(REG_INDEX, 32'h20);
      axw(REG_STACK, 32'h100);
      chk(bq, RESP_OKAY);
      foreach (rows[i]) begin
         cop(rows[i].m, rows[i].f, rows[i].p, 16'h0, 1'b0, 1'b0);
         e = dat(ph(rows[i].l));
         if (rows[i].m inside {MODE_ISCR, MODE_IREL}) e = dat(ph({e[14:0], 1'b0}));
         chk(got, e);
      end
      dly <= 4'h3;
      axr(REG_STACK);
      chk(rd, 32'h100);
      cop(MODE_PUSH, 16'h0, 16'h0, 16'h1234, 1'b1, 1'b0);
      axr(REG_STACK);
      chk(rd, 32'hff);
      cop(MODE_POP, 16'h0, 16'h0, 16'h0, 1'b0, 1'b0);
      chk(got, 16'h1234);
      axr(REG_STACK);
      chk(rd, 32'h100);
      n0 = nmem;
      cop(MODE_SCR, 16'h0040, 16'h0, 16'h0, 1'b0, 1'b0);
      cop(MODE_SCR, 16'h0040, 16'h0, 16'h0, 1'b0, 1'b0);
      chk(got, dat(ph(16'h0080)));
      chk(nmem - n0, 1);
      axw(REG_CTRL, 32'h1);
      b0 = nbyte;
      cop(MODE_SCR, 16'h0081, 16'h0, 16'h0, 1'b0, 1'b0);
      cop(MODE_SCR, 16'h0081, 16'h0, 16'h0, 1'b0, 1'b0);
      chk(nbyte - b0, 2);
      e = dat(ph(16'h0080));
      chk(got, {8'h00, e[15:8]});
      cop(MODE_REL, 16'h03ff, 16'h0400, 16'h0, 1'b0, 1'b0);
      e = dat(ph(16'h0a00));
      chk(got, {8'h00, e[7:0]});
      axw(REG_CTRL, 32'h10);
      cop(MODE_SCR, 16'h0002, 16'h0, 16'h0, 1'b0, 1'b0);
      chk(got, dat({8'h77, 11'h004}));
      axw(REG_CTRL, 32'h100);
      cop(MODE_SCR, 16'h0008, 16'h0, 16'h0, 1'b0, 1'b1);
      chk(got, dat({8'h77, 11'h008}));
      irq <= 1'b1;
      repeat (2) @(posedge clk);
      chk(itk, 1'b0);
      axw(REG_CTRL, 32'h2);
      repeat (2) @(posedge clk);
      chk(itk, 1'b1);
      ovf <= 1'b1;
      @(posedge clk);
      ovf <= 1'b0;
      axr(REG_STAT);
      chk(rd[STAT_ARF], 1'b1);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      chk(itk, 1'b0);
      axr(REG_STAT);
      chk(rd, 32'h0);
      axw(8'h06, 32'h0);
      chk(bq, RESP_SLVERR);
      axr(8'h1c);
      chk(rr, RESP_SLVERR);
      report_and_stop;
   end
endmodule // tb
